// ---- pkg/qtimer_pkg.sv ----
// constants, field layouts and bus carriers of the timer register block
package qtimer_pkg;
    localparam int NUM_CHAN = 3;
    localparam int ADDR_W = 8;
    // per-channel offsets
    localparam logic [1:0] CHAN_LAST = 2'h2;
    localparam logic [5:0] OFF_CHAN_CMD = 6'h00;
    localparam logic [5:0] OFF_CHAN_MODE = 6'h04;
    localparam logic [5:0] OFF_STEPPER = 6'h08;
    localparam logic [5:0] OFF_COUNTER = 6'h10;
    localparam logic [5:0] OFF_CAP_A = 6'h14;
    localparam logic [5:0] OFF_CAP_B = 6'h18;
    localparam logic [5:0] OFF_PERIOD_C = 6'h1C;
    localparam logic [5:0] OFF_CHAN_STATUS = 6'h20;
    localparam logic [5:0] OFF_CHAN_IRQ_EN = 6'h24;
    localparam logic [5:0] OFF_CHAN_IRQ_DIS = 6'h28;
    localparam logic [5:0] OFF_CHAN_IRQ_MASK = 6'h2C;
    // block offsets
    localparam logic [7:0] OFF_BLOCK_CMD = 8'hC0;
    localparam logic [7:0] OFF_BLOCK_MODE = 8'hC4;
    localparam logic [7:0] OFF_DEC_IRQ_EN = 8'hC8;
    localparam logic [7:0] OFF_DEC_IRQ_DIS = 8'hCC;
    localparam logic [7:0] OFF_DEC_IRQ_MASK = 8'hD0;
    localparam logic [7:0] OFF_DEC_IRQ_STAT = 8'hD4;
    localparam logic [7:0] OFF_WLOCK = 8'hE4;
    // command, mode and status bits
    localparam int CMD_CLOCK_ON = 0;
    localparam int CMD_CLOCK_OFF = 1;
    localparam int CMD_SOFT_TRIG = 2;
    localparam int CMD_BLOCK_TRIG = 0;
    localparam int MODE_WAVE = 15;
    localparam int STATUS_CLOCK_ON = 16;
    // block mode fields
    localparam int SEL0_LSB = 0;
    localparam int SEL1_LSB = 2;
    localparam int SEL2_LSB = 4;
    localparam int BM_DEC_EN = 8;
    localparam int BM_POS_EN = 9;
    localparam int BM_SPEED_EN = 10;
    localparam int BM_BYPASS = 11;
    localparam int BM_SINGLE = 12;
    localparam int BM_INV_A = 13;
    localparam int BM_INV_B = 14;
    localparam int BM_INV_IDX = 15;
    localparam int BM_SWAP = 16;
    localparam int BM_IDX_ROUTE = 17;
    localparam int BM_FILT_EN = 19;
    localparam int DEB_LSB = 20;
    localparam int DEB_W = 6;
    localparam logic [31:0] BLOCK_MODE_MASK = 32'h03FB_FF3F;
    localparam logic [1:0] SEL_PIN = 2'h0;
    localparam logic [1:0] SEL_ALT = 2'h2;
    localparam logic [1:0] SEL_CHAN2 = 2'h3;
    // decoder flags, direction bit and gap counter width
    localparam int Q_INDEX = 0;
    localparam int Q_REVERSAL = 1;
    localparam int Q_FAULT = 2;
    localparam int Q_DIR = 8;
    localparam int GAP_W = 7;
    // write lock and bus response codes
    localparam int WL_EN = 0;
    localparam int WL_KEY_LSB = 8;
    localparam logic [23:0] WL_KEY = 24'h54_494D;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axil_rsp_t;
endpackage

// ---- hw/qtimer_regs.sv ----
// register interface, clock nets and quadrature front end of the timer block
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
module qtimer_regs
    import qtimer_pkg::*;
(
    // clock, reset, enable
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    // register bus
    input wire axil_req_t axil_req_i,
    output axil_rsp_t axil_rsp_o,
    // pins
    input wire logic [2:0] ext_clock_pin_i,
    input wire logic [2:0] chan_line_a_i,
    input wire logic chan0_line_b_i,
    // counting logic
    input wire logic [2:0][15:0] counter_value_i,
    // outputs to counting logic
    output logic [2:0] ext_clock_net_o,
    output logic [2:0] chan_clock_on_o,
    output logic [2:0] chan_trigger_o,
    output logic quad_edge_o,
    output logic quad_dir_o,
    output logic index_pulse_o,
    output logic position_mode_o,
    output logic speed_mode_o,
    output logic decoder_irq_o
);

    typedef struct packed {
        logic [6:0] sync1;
        logic [6:0] sync2;
        logic [2:0][DEB_W-1:0] filt_cnt;
        logic [2:0] filt_val;
        logic [2:0] prev;
        logic last_b;
        logic [GAP_W-1:0] gap;
        logic dir;
        logic [2:0] qstat;
        logic [2:0] qmask;
        logic [31:0] block_mode;
        logic wlock;
        logic [2:0][31:0] chan_mode;
        logic [2:0][31:0] stepper;
        logic [2:0][31:0] cap_a;
        logic [2:0][31:0] cap_b;
        logic [2:0][31:0] period_c;
        logic [2:0][7:0] chan_mask;
        logic [2:0] clk_on;
        logic [2:0] trig;
        logic [2:0] ext_net;
        logic edge_p;
        logic index_p;
        logic pos_mode;
        logic speed_mode;
        logic irq;
        logic aw_held;
        logic w_held;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        axil_rsp_t rsp;
    } state_t;

    state_t s_reg;
    state_t s_next;

    // byte lanes of a write merged into an old value
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic net_sel(input logic [1:0] sel, input logic pin,
                                     input logic alt, input logic ch2);
        logic r;
        r = 1'b0;
        unique case (sel)
            SEL_PIN: r = pin;
            SEL_ALT: r = alt;
            SEL_CHAN2: r = ch2;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // channel part of an address, invalid above the last channel
    function automatic logic chan_hit(input logic [ADDR_W-1:0] a);
        return a[7:6] <= CHAN_LAST;
    endfunction

    logic [2:0] pin_a;
    logic pin_b;
    logic [2:0] pin_clk;
    logic [DEB_W-1:0] deb;
    logic dec_en;
    logic [2:0] raw;
    logic qa;
    logic qb;
    logic qi;
    logic ea;
    logic eb;
    logic new_dir;
    logic [2:0] qset;
    logic [2:0] qclr;
    logic wr;
    logic [1:0] wch;
    logic [5:0] woff;
    logic [31:0] wd;
    logic rd;
    logic [1:0] rch;
    logic [5:0] roff;
    logic [31:0] rdat;
    logic rok;
    logic wok;
    logic protect;
    logic [2:0] trig_all;

    always_comb begin
        s_next = s_reg;
        pin_a = s_reg.sync2[2:0];
        pin_b = s_reg.sync2[3];
        pin_clk = s_reg.sync2[6:4];
        s_next.sync1 = {ext_clock_pin_i, chan0_line_b_i, chan_line_a_i};
        s_next.sync2 = s_reg.sync1;
        deb = s_reg.block_mode[DEB_LSB +: DEB_W];
        dec_en = s_reg.block_mode[BM_DEC_EN];
        protect = s_reg.wlock;

        // external clock nets
        s_next.ext_net[0] = net_sel(s_reg.block_mode[SEL0_LSB +: 2],
                                    pin_clk[0], pin_a[1], pin_a[2]);
        s_next.ext_net[1] = net_sel(s_reg.block_mode[SEL1_LSB +: 2],
                                    pin_clk[1], pin_a[0], pin_a[2]);
        s_next.ext_net[2] = net_sel(s_reg.block_mode[SEL2_LSB +: 2],
                                    pin_clk[2], pin_a[1], pin_a[2]);

        // input filter: phase A, phase B, index on channel 1 line A
        raw = {pin_a[1], pin_b, pin_a[0]};
        for (int i = 0; i < 3; i++) begin
            if (!dec_en || !s_reg.block_mode[BM_FILT_EN]) begin
                s_next.filt_val[i] = raw[i];
                s_next.filt_cnt[i] = '0;
            end else if (raw[i] == s_reg.filt_val[i]) begin
                s_next.filt_cnt[i] = '0;
            end else if (s_reg.filt_cnt[i] >= deb) begin
                // level held for deb+1 samples before it is accepted
                s_next.filt_val[i] = raw[i];
                s_next.filt_cnt[i] = '0;
            end else begin
                s_next.filt_cnt[i] = s_reg.filt_cnt[i] + 1'b1;
            end
        end

        // polarity, exchange and index routing
        qa = s_reg.filt_val[0] ^ s_reg.block_mode[BM_INV_A];
        qb = s_reg.filt_val[1] ^ s_reg.block_mode[BM_INV_B];
        if (s_reg.block_mode[BM_SWAP]) begin
            {qa, qb} = {qb, qa};
        end
        qi = (s_reg.block_mode[BM_IDX_ROUTE] ? s_reg.filt_val[1]
              : s_reg.filt_val[2]) ^ s_reg.block_mode[BM_INV_IDX];
        s_next.prev = {qi, qb, qa};

        // edges and direction
        ea = dec_en && (qa != s_reg.prev[0]);
        eb = dec_en && (qb != s_reg.prev[1])
             && !s_reg.block_mode[BM_SINGLE];
        new_dir = s_reg.dir;
        if (ea) begin
            new_dir = qa ^ qb;
        end else if (eb) begin
            new_dir = ~(qa ^ qb);
        end
        qset = '0;
        if ((ea || eb) && !s_reg.block_mode[BM_BYPASS]) begin
            s_next.dir = new_dir;
            qset[Q_REVERSAL] = new_dir != s_reg.dir;
        end
        // two phase edges no more than deb+1 cycles apart is a fault
        if ((ea && eb) || (ea && s_reg.last_b && s_reg.gap <= GAP_W'(deb))
            || (eb && !s_reg.last_b && s_reg.gap <= GAP_W'(deb))) begin
            qset[Q_FAULT] = 1'b1;
        end
        if (ea || eb) begin
            s_next.gap = '0;
            s_next.last_b = eb && !ea;
        end else if (s_reg.gap != '1) begin
            s_next.gap = s_reg.gap + 1'b1;
        end
        qset[Q_INDEX] = dec_en && qi && !s_reg.prev[2];
        s_next.edge_p = ea || eb;
        s_next.index_p = qset[Q_INDEX];
        s_next.pos_mode = dec_en && s_reg.block_mode[BM_POS_EN];
        s_next.speed_mode = dec_en && s_reg.block_mode[BM_SPEED_EN];

        // register bus: write side
        s_next.trig = '0;
        trig_all = '0;
        s_next.rsp.bvalid = s_reg.rsp.bvalid && !axil_req_i.bready;
        if (axil_req_i.awvalid && s_reg.rsp.awready) begin
            s_next.aw_held = 1'b1;
            s_next.awaddr = axil_req_i.awaddr;
        end
        if (axil_req_i.wvalid && s_reg.rsp.wready) begin
            s_next.w_held = 1'b1;
            s_next.wdata = axil_req_i.wdata;
            s_next.wstrb = axil_req_i.wstrb;
        end
        wr = s_reg.aw_held && s_reg.w_held && !s_reg.rsp.bvalid;
        wch = s_reg.awaddr[7:6];
        woff = s_reg.awaddr[5:0];
        wd = s_reg.wdata;
        wok = 1'b0;
        if (wr) begin
            wok = 1'b1;
            if (chan_hit(s_reg.awaddr)) begin
                unique case (woff)
                    OFF_CHAN_CMD: begin
                        if (s_reg.wstrb[0]) begin
                            if (wd[CMD_CLOCK_OFF]) begin
                                s_next.clk_on[wch] = 1'b0;
                            end else if (wd[CMD_CLOCK_ON]) begin
                                s_next.clk_on[wch] = 1'b1;
                            end
                            if (wd[CMD_SOFT_TRIG]) begin
                                s_next.trig[wch] = 1'b1;
                            end
                        end
                    end
                    OFF_CHAN_MODE: if (!protect) begin
                        s_next.chan_mode[wch] = merge(s_reg.chan_mode[wch],
                                                      wd, s_reg.wstrb);
                    end
                    OFF_STEPPER: if (!protect) begin
                        s_next.stepper[wch] = merge(s_reg.stepper[wch],
                                                    wd, s_reg.wstrb);
                    end
                    OFF_CAP_A: begin
                        if (!protect && s_reg.chan_mode[wch][MODE_WAVE]) begin
                            s_next.cap_a[wch] = merge(s_reg.cap_a[wch],
                                                      wd, s_reg.wstrb);
                        end
                    end
                    OFF_CAP_B: begin
                        if (!protect && s_reg.chan_mode[wch][MODE_WAVE]) begin
                            s_next.cap_b[wch] = merge(s_reg.cap_b[wch],
                                                      wd, s_reg.wstrb);
                        end
                    end
                    OFF_PERIOD_C: if (!protect) begin
                        s_next.period_c[wch] = merge(s_reg.period_c[wch],
                                                     wd, s_reg.wstrb);
                    end
                    OFF_CHAN_IRQ_EN: if (s_reg.wstrb[0]) begin
                        s_next.chan_mask[wch] = s_reg.chan_mask[wch]
                                                | wd[7:0];
                    end
                    OFF_CHAN_IRQ_DIS: if (s_reg.wstrb[0]) begin
                        s_next.chan_mask[wch] = s_reg.chan_mask[wch]
                                                & ~wd[7:0];
                    end
                    OFF_COUNTER, OFF_CHAN_STATUS, OFF_CHAN_IRQ_MASK: ;
                    default: wok = 1'b0;
                endcase
            end else begin
                unique case (s_reg.awaddr)
                    OFF_BLOCK_CMD: begin
                        if (s_reg.wstrb[0] && wd[CMD_BLOCK_TRIG]) begin
                            trig_all = '1;
                        end
                    end
                    OFF_BLOCK_MODE: if (!protect) begin
                        s_next.block_mode = merge(s_reg.block_mode, wd,
                                s_reg.wstrb) & BLOCK_MODE_MASK;
                    end
                    OFF_DEC_IRQ_EN: if (s_reg.wstrb[0]) begin
                        s_next.qmask = s_reg.qmask | wd[2:0];
                    end
                    OFF_DEC_IRQ_DIS: if (s_reg.wstrb[0]) begin
                        s_next.qmask = s_reg.qmask & ~wd[2:0];
                    end
                    OFF_WLOCK: begin
                        // key spans the upper three lanes
                        if (&s_reg.wstrb
                            && wd[WL_KEY_LSB +: 24] == WL_KEY) begin
                            s_next.wlock = wd[WL_EN];
                        end
                    end
                    OFF_DEC_IRQ_MASK, OFF_DEC_IRQ_STAT: ;
                    default: wok = 1'b0;
                endcase
            end
            s_next.aw_held = 1'b0;
            s_next.w_held = 1'b0;
            s_next.rsp.bvalid = 1'b1;
            s_next.rsp.bresp = wok ? RESP_OKAY : RESP_SLVERR;
        end
        // a trigger always starts the clock, even against a clock-off
        s_next.trig = s_next.trig | trig_all;
        s_next.clk_on = s_next.clk_on | s_next.trig;

        // register bus: read side
        qclr = '0;
        s_next.rsp.rvalid = s_reg.rsp.rvalid && !axil_req_i.rready;
        rd = axil_req_i.arvalid && s_reg.rsp.arready;
        rch = axil_req_i.araddr[7:6];
        roff = axil_req_i.araddr[5:0];
        rdat = '0;
        rok = 1'b1;
        if (chan_hit(axil_req_i.araddr)) begin
            unique case (roff)
                OFF_CHAN_MODE: rdat = s_reg.chan_mode[rch];
                OFF_STEPPER: rdat = s_reg.stepper[rch];
                OFF_COUNTER: rdat = {16'h0000, counter_value_i[rch]};
                OFF_CAP_A: rdat = s_reg.cap_a[rch];
                OFF_CAP_B: rdat = s_reg.cap_b[rch];
                OFF_PERIOD_C: rdat = s_reg.period_c[rch];
                OFF_CHAN_STATUS: rdat[STATUS_CLOCK_ON] = s_reg.clk_on[rch];
                OFF_CHAN_IRQ_MASK: rdat[7:0] = s_reg.chan_mask[rch];
                OFF_CHAN_CMD, OFF_CHAN_IRQ_EN, OFF_CHAN_IRQ_DIS: ;
                default: rok = 1'b0;
            endcase
        end else begin
            unique case (axil_req_i.araddr)
                OFF_BLOCK_MODE: rdat = s_reg.block_mode;
                OFF_DEC_IRQ_MASK: rdat[2:0] = s_reg.qmask;
                OFF_DEC_IRQ_STAT: begin
                    rdat[2:0] = s_reg.qstat;
                    rdat[Q_DIR] = s_reg.dir;
                    qclr = rd ? 3'b111 : 3'b000;
                end
                OFF_WLOCK: rdat[WL_EN] = s_reg.wlock;
                OFF_BLOCK_CMD, OFF_DEC_IRQ_EN, OFF_DEC_IRQ_DIS: ;
                default: rok = 1'b0;
            endcase
        end
        if (rd) begin
            s_next.rsp.rvalid = 1'b1;
            s_next.rsp.rdata = rdat;
            s_next.rsp.rresp = rok ? RESP_OKAY : RESP_SLVERR;
        end

        // an event in the clearing cycle survives the read
        s_next.qstat = (s_reg.qstat & ~qclr) | qset;
        s_next.irq = |(s_next.qstat & s_next.qmask);

        // ready flags registered so the outputs leave flops directly
        s_next.rsp.awready = !s_next.aw_held && !s_next.rsp.bvalid;
        s_next.rsp.wready = !s_next.w_held && !s_next.rsp.bvalid;
        s_next.rsp.arready = !s_next.rsp.rvalid;
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            s_reg <= '0;
        end else if (ce_i) begin
            s_reg <= s_next;
        end
    end

    assign axil_rsp_o = s_reg.rsp;
    assign ext_clock_net_o = s_reg.ext_net;
    assign chan_clock_on_o = s_reg.clk_on;
    assign chan_trigger_o = s_reg.trig;
    assign quad_edge_o = s_reg.edge_p;
    assign quad_dir_o = s_reg.dir;
    assign index_pulse_o = s_reg.index_p;
    assign position_mode_o = s_reg.pos_mode;
    assign speed_mode_o = s_reg.speed_mode;
    assign decoder_irq_o = s_reg.irq;

endmodule

// ---- bench/qtimer_assertions.sv ----
// port-level checks of the timer register block
`timescale 1ns/1ps
module qtimer_checker
    import qtimer_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // register bus
    input wire axil_req_t axil_req_i,
    input wire axil_rsp_t axil_rsp_o,
    // channel controls
    input wire logic [2:0] chan_clock_on_o,
    input wire logic [2:0] chan_trigger_o
);
    logic aw_q, w_q, aw_hs, w_hs, go;
    logic [7:0] a_q, wa;
    logic [31:0] d_q, wd;
    // address and data may be taken in either order
    assign aw_hs = axil_req_i.awvalid && axil_rsp_o.awready;
    assign w_hs = axil_req_i.wvalid && axil_rsp_o.wready;
    assign go = (aw_hs || aw_q) && (w_hs || w_q);
    assign wa = aw_hs ? axil_req_i.awaddr : a_q;
    assign wd = w_hs ? axil_req_i.wdata : d_q;
    always_ff @(posedge mclk_i) begin
        aw_q <= nrst_i && !go && (aw_q || aw_hs);
        w_q <= nrst_i && !go && (w_q || w_hs);
        a_q <= aw_hs ? axil_req_i.awaddr : a_q;
        d_q <= w_hs ? axil_req_i.wdata : d_q;
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    block_trig_a: assert property (
        go && wa == OFF_BLOCK_CMD && wd[0] |-> ##[1:3] chan_trigger_o == 3'h7)
        else $error("block trigger missed");
    trig_pulse_a: assert property (
        chan_trigger_o != 3'h0 |=> chan_trigger_o == 3'h0)
        else $error("trigger longer than one cycle");
    clock_off_a: assert property (
        go && wa == 8'h00 && wd[2:0] == 3'h3 |-> ##[1:3] !chan_clock_on_o[0])
        else $error("clock off lost to clock on");
    clock_on_a: assert property (
        go && wa == 8'h40 && wd[2:0] == 3'h1 |-> ##[1:3] chan_clock_on_o[1])
        else $error("clock on ignored");
    soft_trig_a: assert property (
        go && wa == 8'h80 && wd[2] |-> ##[1:3] chan_trigger_o == 3'h4 ##[0:2]
        chan_clock_on_o[2]) else $error("soft trigger wrong");
    read_answer_a: assert property (
        axil_req_i.arvalid && axil_rsp_o.arready |=> axil_rsp_o.rvalid)
        else $error("read not answered");
    unmapped_a: assert property (
        axil_req_i.arvalid && axil_rsp_o.arready && axil_req_i.araddr == 8'hFC
        |=> axil_rsp_o.rresp == RESP_SLVERR) else $error("unmapped read ok");
    busy_write_a: assert property (
        axil_rsp_o.bvalid |-> !axil_rsp_o.awready && !axil_rsp_o.wready)
        else $error("write taken while busy");
endmodule

// ---- bench/rotary_sensor_model.sv ----
// rotary sensor: gray phases, index one step a turn
`timescale 1ns/1ps
module rotary_sensor_model (
    // clock
    input wire logic mclk_i,
    // sensor pins
    output logic quad_first_o,
    output logic quad_second_o,
    output logic index_o
);
    logic [1:0] pos = 2'h0;
    assign quad_first_o = pos[1];
    assign quad_second_o = pos[1] ^ pos[0];
    initial index_o = 1'b0;
    // one phase moves per step, so real motion never looks like a fault
    task automatic step(input bit back, input int gap);
        repeat (gap) @(posedge mclk_i);
        pos <= back ? pos - 2'h1 : pos + 2'h1;
        index_o <= (pos == 2'h3) && !back;
    endtask
    // contamination: first phase alone flips for w cycles
    task automatic glitch(input int w);
        @(posedge mclk_i);
        pos <= pos ^ 2'h3;
        repeat (w) @(posedge mclk_i);
        pos <= pos ^ 2'h3;
    endtask
endmodule

// ---- bench/timer_block_quadrature_control_test.sv ----
// self-checking bench of the timer register block
`timescale 1ns/1ps
module timer_block_quadrature_control_test;
    import qtimer_pkg::*;
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    axil_req_t req = '0;
    axil_rsp_t rsp;
    logic [2:0] pin = 3'h0;
    logic [2:0] net, clk_on;
    logic [2:0][15:0] cv = 48'h1234_5678_9ABC;
    logic la2 = 1'b0;
    logic quad_first_input, quad_second_input, idx_w, qe, dir, pmode, smode, irq, d0, ip;
    logic [31:0] lfsr = 32'h0000_005F;
    logic [31:0] v;
    logic [31:0] pc [3];
    logic [1:0] rcode;
    int n_errors = 0;
    int checked = 0;
    int edges = 0;
    int idxs = 0;
    qtimer_regs i_dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(1'b1),
        .axil_req_i(req), .axil_rsp_o(rsp), .ext_clock_pin_i(pin),
        .chan_line_a_i({la2, idx_w, quad_first_input}), .chan0_line_b_i(quad_second_input),
        .counter_value_i(cv), .ext_clock_net_o(net),
        .chan_clock_on_o(clk_on), .chan_trigger_o(), .quad_edge_o(qe),
        .quad_dir_o(dir), .index_pulse_o(ip), .position_mode_o(pmode),
        .speed_mode_o(smode), .decoder_irq_o(irq));
    rotary_sensor_model i_sensor (.mclk_i(mclk_i), .quad_first_o(quad_first_input),
        .quad_second_o(quad_second_input), .index_o(idx_w));
    initial forever #5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) if (qe === 1'b1) edges <= edges + 1;
    always @(posedge mclk_i) if (ip === 1'b1) idxs <= idxs + 1;
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    function automatic logic [7:0] ca(input int n, input logic [5:0] o);
        return {n[1:0], o};
    endfunction
    function automatic logic [2:0] nets(input logic [1:0] s, logic [2:0] a);
        case (s)
            2'h0: return pin;
            2'h2: return {a[1], a[0], a[1]};
            2'h3: return {3{a[2]}};
            default: return 3'h0;
        endcase
    endfunction
    task automatic conclude();
        if (n_errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", s, e, g);
        end
    endtask
    // the master never assumes a latency; a wait ends on the response or after 50 cycles
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int t;
        @(posedge mclk_i);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.bready <= 1'b1;
        for (t = 0; t < 50; t++) begin
            @(posedge mclk_i);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid) break;
        end
        req.bready <= 1'b0;
        if (t == 50) begin
            n_errors++;
            conclude();
        end
    endtask
    task automatic rd(input logic [7:0] a);
        int t;
        @(posedge mclk_i);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        for (t = 0; t < 50; t++) begin
            @(posedge mclk_i);
            if (rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid) break;
        end
        req.rready <= 1'b0;
        v = rsp.rdata;
        rcode = rsp.rresp;
        if (t == 50) begin
            n_errors++;
            conclude();
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk($sformatf("reg %h", a), e, v);
    endtask
    task automatic steps(input int n, input bit back);
        repeat (n) i_sensor.step(back, 8);
        repeat (8) @(posedge mclk_i);
    endtask
    initial begin
        repeat (5) @(posedge mclk_i);
        nrst_i <= 1'b1;
        rc(OFF_BLOCK_MODE, 32'h0000_0000);
        rc(OFF_WLOCK, 32'h0000_0000);
        rc(ca(1, OFF_COUNTER), {16'h0000, cv[1]});
        rd(8'hFC);
        chk("resp", RESP_SLVERR, rcode);
        for (int n = 0; n < 3; n++) begin
            pc[n] = rnd();
            wr(ca(n, OFF_PERIOD_C), pc[n]);
        end
        for (int n = 0; n < 3; n++) rc(ca(n, OFF_PERIOD_C), pc[n]);
        wr(ca(2, OFF_CAP_A), rnd());
        rc(ca(2, OFF_CAP_A), 32'h0000_0000);
        wr(ca(2, OFF_CHAN_MODE), 32'h0000_8000);
        pc[0] = rnd();
        wr(ca(2, OFF_CAP_B), pc[0]);
        rc(ca(2, OFF_CAP_B), pc[0]);
        wr(OFF_WLOCK, 32'h5449_4C01);
        rc(OFF_WLOCK, 32'h0000_0000);
        wr(OFF_WLOCK, {WL_KEY, 8'h01});
        rc(OFF_WLOCK, 32'h0000_0001);
        wr(OFF_BLOCK_MODE, 32'h0000_0030);
        rc(OFF_BLOCK_MODE, 32'h0000_0000);
        wr(OFF_WLOCK, {WL_KEY, 8'h00});
        wr(OFF_BLOCK_CMD, 32'h0000_0001);
        chk("clock on", 3'h7, clk_on);
        wr(ca(0, OFF_CHAN_CMD), 32'h0000_0003);
        wr(ca(1, OFF_CHAN_CMD), 32'h0000_0002);
        wr(ca(1, OFF_CHAN_CMD), 32'h0000_0001);
        wr(ca(1, OFF_CHAN_CMD), 32'h0000_0000);
        wr(ca(2, OFF_CHAN_CMD), 32'h0000_0002);
        wr(ca(2, OFF_CHAN_CMD), 32'h0000_0004);
        chk("clock on", 3'h6, clk_on);
        wr(OFF_DEC_IRQ_EN, 32'h0000_0007);
        rc(OFF_DEC_IRQ_MASK, 32'h0000_0007);
        wr(OFF_DEC_IRQ_DIS, 32'h0000_0006);
        rc(OFF_DEC_IRQ_MASK, 32'h0000_0001);
        wr(OFF_BLOCK_MODE, 32'h0000_0300);
        // mode outputs follow the mode register one edge later
        @(posedge mclk_i);
        chk("modes", 2'h2, {pmode, smode});
        rd(OFF_DEC_IRQ_STAT);
        edges = 0;
        steps(4, 1'b0);
        chk("edges", 4, edges);
        chk("irq", 1, irq);
        d0 = dir;
        rc(OFF_DEC_IRQ_STAT, {23'h0, d0, 8'h01});
        rd(OFF_DEC_IRQ_STAT);
        chk("index flag", 0, v[Q_INDEX]);
        chk("irq", 0, irq);
        steps(3, 1'b1);
        rd(OFF_DEC_IRQ_STAT);
        chk("reversal", 1, v[Q_REVERSAL]);
        for (int k = 0; k < 3; k++) begin
            wr(OFF_BLOCK_MODE, 32'h0000_0300 | (32'h1 << (13 + k + k / 2)));
            steps(2, 1'b0);
            chk("dir", !d0, dir);
        end
        wr(OFF_BLOCK_MODE, 32'h0000_0B00);
        rd(OFF_DEC_IRQ_STAT);
        // mode changes above flipped both phases in one cycle
        chk("fault", 1, v[Q_FAULT]);
        steps(3, 1'b0);
        steps(3, 1'b1);
        rd(OFF_DEC_IRQ_STAT);
        chk("reversal", 0, v[Q_REVERSAL]);
        wr(OFF_BLOCK_MODE, 32'h0000_1300);
        edges = 0;
        steps(4, 1'b0);
        chk("edges", 2, edges);
        wr(OFF_BLOCK_MODE, 32'h0002_0300);
        idxs = 0;
        steps(1, 1'b0);
        chk("index", 0, idxs);
        steps(1, 1'b0);
        chk("index", 1, idxs);
        wr(OFF_BLOCK_MODE, 32'h0000_0500);
        @(posedge mclk_i);
        chk("modes", 2'h1, {pmode, smode});
        wr(OFF_BLOCK_MODE, 32'h0038_0300);
        edges = 0;
        i_sensor.glitch(3);
        i_sensor.glitch(4);
        repeat (12) @(posedge mclk_i);
        chk("edges", 2, edges);
        for (int s = 0; s < 4; s++) begin
            v = rnd();
            pin <= v[2:0];
            la2 <= v[3];
            wr(OFF_BLOCK_MODE, {26'h0, {3{s[1:0]}}});
            repeat (4) @(posedge mclk_i);
            v = {29'h0, nets(s[1:0], {la2, idx_w, quad_first_input})};
            chk("nets", v, net);
        end
        conclude();
    end
endmodule
bind qtimer_regs qtimer_checker i_chk (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .axil_req_i(axil_req_i), .axil_rsp_o(axil_rsp_o),
    .chan_clock_on_o(chan_clock_on_o), .chan_trigger_o(chan_trigger_o));
